// ===== tb/fp_arith_bounce_detector_tb_top.sv
// Self-checking bench for the arithmetic bounce detector
`timescale 1ns/1ps

module fp_arith_bounce_detector_tb_top;
   import fp_bounce_pkg::*;

   typedef struct {
      logic [31:0] m;
      logic [31:0] v;
      logic        e;
   } note_t;

   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              bounce;
   logic              exception_pending_bit;
   logic              hung;
   note_t             notes[$];
   note_t             cur;
   int                fail_count;
   int                check_count;
   logic [15:0]       lf;
   logic [11:0]       opc;
   logic [11:0]       ra;
   logic [11:0]       rb;
   logic [1:0]        s;
   logic              lk;
   fp_op_t            op;
   fp_op_t            nb[5] = '{OP_SQRT, OP_CPY, OP_ABS, OP_NEG, OP_CVT_SD};

   fp_arith_bounce_detector u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bounce(bounce),
      .exception_pending_bit(exception_pending_bit)
   );

   host_core_model u_host (
      .pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung)
   );

   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] x);
      check_count++;
      if (seen !== x) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, x);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] v, input logic e);
      note_t n;
      n.m = m;
      n.v = v;
      n.e = e;
      notes.push_back(n);
      u_host.xfer(1'b0, a, 32'h0);
   endtask

   // x holds like, underflow, overflow, bounce as RESULT[3:0]
   task automatic run(input fp_op_t op, input logic dp, input logic [11:0] a,
                      input logic [11:0] b, input logic [3:0] x,
                      input exp_t e);
      logic [31:0] m;
      m = 32'h37;
      if (op <= OP_CMPEZ || (op >= OP_MAC && op <= OP_NMSC)) begin
         m[3] = 1'b1;
      end
      if (op <= OP_DIV || op == OP_CVT_DS) begin
         m[29:16] = 14'h3FFF;
      end
      u_host.xfer(1'b1, REG_EXC, 32'h8000_000C);
      u_host.xfer(1'b1, REG_OPND_A, {20'h0, a});
      u_host.xfer(1'b1, REG_OPND_B, {20'h0, b});
      u_host.xfer(1'b1, REG_OPND_C, {20'h0, opc});
      u_host.xfer(1'b1, REG_ISSUE, {23'h0, dp, 3'h0, op});
      @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, bounce}, {31'h0, x[0]});
      chk({31'h0, exception_pending_bit}, {31'h0, x[0]});
      rd(REG_RESULT, m, {2'b0, e, 10'h0, 2'b01, x} & m, 1'b0);
      rd(REG_EXC, 32'hFFFF_FFFF, {x[0], 27'h0, x[2], x[1], 2'h0}, 1'b0);
   endtask

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (notes.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            cur = notes.pop_front();
            chk(prdata & cur.m, cur.v);
            chk({31'h0, pslverr}, {31'h0, cur.e});
         end
      end
   end

   // A stuck bus counts as a mismatch
   always @(posedge hung) begin
      fail_count++;
      finish_test();
   end

   initial begin
      presetn = 1'b0;
      fail_count = 0;
      check_count = 0;
      lf = 16'h000B;
      opc = 12'h000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({30'h0, bounce, exception_pending_bit}, 32'h0);
      rd(REG_CTRL, 32'hFFFF_FFFF, 32'h0, 1'b0);
      rd(REG_RESULT, 32'hFFFF_FFFF, 32'h0, 1'b0);
      rd(REG_EXC, 32'hFFFF_FFFF, 32'h0, 1'b0);
      u_host.xfer(1'b1, REG_CTRL, 32'h3);
      rd(REG_CTRL, 32'h3, 32'h3, 1'b0);
      rd(8'h1C, 32'hFFFF_FFFF, 32'h0, 1'b1);
      u_host.xfer(1'b1, REG_CTRL, 32'h2);
      run(OP_MUL, 1'b1, 12'h200, 12'h1FF, 4'b0000, 14'h000);
      run(OP_MUL, 1'b1, 12'h7FD, 12'h3FF, 4'b0011, 14'h7FD);
      u_host.xfer(1'b1, REG_CTRL, 32'h1);
      run(OP_ADD, 1'b1, 12'h03F, 12'h83F, 4'b0000, 14'h03F);
      u_host.xfer(1'b1, REG_CTRL, 32'h0);
      run(OP_ADD, 1'b1, 12'h7FD, 12'h001, 4'b1011, 14'h7FD);
      run(OP_ADD, 1'b1, 12'h7FC, 12'h001, 4'b1000, 14'h7FC);
      run(OP_SUB, 1'b1, 12'h7FD, 12'h001, 4'b0011, 14'h7FD);
      run(OP_ADD, 1'b0, 12'h0FD, 12'h001, 4'b1011, 14'h0FD);
      run(OP_ADD, 1'b0, 12'h0FC, 12'h001, 4'b1000, 14'h0FC);
      run(OP_ADD, 1'b0, 12'h01F, 12'h81F, 4'b0101, 14'h01F);
      run(OP_ADD, 1'b0, 12'h020, 12'h820, 4'b0000, 14'h020);
      run(OP_SUB, 1'b0, 12'h01F, 12'h01F, 4'b0101, 14'h01F);
      run(OP_ADD, 1'b1, 12'h83F, 12'h040, 4'b0000, 14'h040);
      run(OP_ADD, 1'b1, 12'h000, 12'h000, 4'b1101, 14'h000);
      run(OP_ADD, 1'b1, 12'h001, 12'h001, 4'b1000, 14'h001);
      run(OP_ADD, 1'b0, 12'h000, 12'h000, 4'b1101, 14'h000);
      run(OP_ADD, 1'b0, 12'h001, 12'h001, 4'b1000, 14'h001);
      for (int i = 0; i < 24; i++) begin
         op = fp_op_t'(i / 4);
         s = i[1:0];
         lk = (op == OP_ADD) ? (s[1] == s[0]) :
              (op >= OP_CMPZ) ? s[1] : (s[1] != s[0]);
         run(op, 1'b1, {s[1], 11'h03F}, {s[0], 11'h03F},
             {lk, !lk, 1'b0, !lk}, 14'h03F);
      end
      run(OP_MUL, 1'b1, 12'h7FC, 12'h3FF, 4'b0000, 14'h7FC);
      run(OP_MUL, 1'b1, 12'h200, 12'h1FF, 4'b0101, 14'h000);
      run(OP_MUL, 1'b1, 12'h200, 12'h200, 4'b0000, 14'h001);
      run(OP_MUL, 1'b0, 12'h0FD, 12'h07F, 4'b0011, 14'h0FD);
      run(OP_MUL, 1'b0, 12'h040, 12'h03F, 4'b0101, 14'h000);
      run(OP_MUL, 1'b0, 12'h040, 12'h040, 4'b0000, 14'h001);
      run(OP_NMUL, 1'b1, 12'h7FD, 12'h3FF, 4'b0011, 14'h7FD);
      run(OP_DIV, 1'b1, 12'h7FD, 12'h3FF, 4'b0011, 14'h7FD);
      run(OP_DIV, 1'b1, 12'h7FC, 12'h3FF, 4'b0000, 14'h7FC);
      run(OP_DIV, 1'b1, 12'h001, 12'h3FF, 4'b0101, 14'h001);
      run(OP_DIV, 1'b1, 12'h002, 12'h3FF, 4'b0000, 14'h002);
      run(OP_DIV, 1'b0, 12'h0FD, 12'h07F, 4'b0011, 14'h0FD);
      run(OP_DIV, 1'b0, 12'h001, 12'h07F, 4'b0101, 14'h001);
      run(OP_DIV, 1'b0, 12'h002, 12'h07F, 4'b0000, 14'h002);
      run(OP_CVT_DS, 1'b1, 12'h47D, 12'h0, 4'b0011, 14'h47D);
      run(OP_CVT_DS, 1'b1, 12'h47C, 12'h0, 4'b0000, 14'h47C);
      run(OP_CVT_DS, 1'b1, 12'h381, 12'h0, 4'b0000, 14'h381);
      run(OP_CVT_DS, 1'b1, 12'h380, 12'h0, 4'b0101, 14'h380);
      opc = 12'h010;
      for (int i = 0; i < 4; i++) begin
         lk = (i == 0 || i == 3);
         run(fp_op_t'(8 + i), 1'b1, 12'h020, 12'h3FF,
             {lk, !lk, 1'b0, !lk}, 14'h020);
      end
      run(OP_MAC, 1'b1, 12'h7FD, 12'h3FF, 4'b1011, 14'h7FD);
      run(fp_op_t'(19), 1'b1, 12'h7FD, 12'h7FD, 4'b0000, 14'h0);
      for (int i = 0; i < 10; i++) begin
         lf = nxt(lf);
         ra = lf[11:0];
         lf = nxt(lf);
         run(nb[i / 2], lf[12], ra, lf[11:0], 4'b0000, 14'h0);
      end
      for (int i = 0; i < 4; i++) begin
         lf = nxt(lf);
         ra = {lf[15], 1'b0, lf[9:0]} + 12'h100;
         lf = nxt(lf);
         rb = {lf[15], 1'b0, lf[9:0]} + 12'h100;
         run(OP_ADD, 1'b1, ra, rb, {ra[11] == rb[11], 3'b0},
             (ra[10:0] > rb[10:0]) ? {3'h0, ra[10:0]} :
             {3'h0, rb[10:0]});
      end
      repeat (2) @(posedge pclk);
      chk(notes.size(), 32'h0);
      finish_test();
   end
endmodule

// ===== tb/host_core_model.sv
// Host core model: APB master that carries the support code's traffic
`timescale 1ns/1ps

module host_core_model
   import fp_bounce_pkg::*;
(
   input  wire logic                             pclk,
   input  wire logic                             pready,
   output logic                                  psel,
   output logic                                  penable,
   output logic                                  pwrite,
   output logic      [fp_bounce_pkg::ADDR_W-1:0] paddr,
   output logic      [fp_bounce_pkg::DATA_W-1:0] pwdata,
   output logic                                  hung
);
   import fp_bounce_pkg::*;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      hung = 1'b0;
   end

   // Request held until pready is seen; bounded so a dead slave ends the run
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) begin
         hung <= 1'b1;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data must not look like a held value
      pwdata <= ~d;
   endtask
endmodule

// ===== verilog/fp_arith_bounce_detector.sv
// APB-controlled detector of pessimistic overflow/underflow bounces
//
// What this block does
// - Any operation hitting an overflow threshold, or an underflow threshold outside both flush modes, is bounced.
// - Add, subtract, compare use the larger operand exponent.
// - Add splits like/unlike by equal signs; subtract and compare inverted.
// - Exponents are 11-bit double, 8-bit single, thresholds in hex.
// - Like-sign add overflows at 7FD double, FD single; 47D converted.
// - Unlike-sign add shares the like-sign overflow range.
// - Unlike-sign add underflows at 1F single, 03F double or below.
// - Like-sign add underflows only at exponent zero or below.
// - Multiply uses the sum of operand exponents.
// - Multiply overflows at 7FD double, FD single.
// - Outside fast and flush-to-zero modes, multiply underflows at zero or below.
// - Multiply-accumulate family reuses add and multiply thresholds.
// - Divide uses the dividend minus divisor exponent.
// - Divide overflows at 7FD double, FD single.
// - Divide underflows at 01 single, 001 double or below.
// - Square root never bounces.
// - Copy, absolute value and negate never bounce.
// - Only double-to-single conversion can bounce.
// - Double-to-single bounces at 47D or above; 47C..381 complete.
// - Double-to-single bounces at 380 or below.
// - Overflow bounce sets pending and overflow bits; status flag clear.
// - Underflow bounce sets pending and underflow bits; registers valid.
`timescale 1ns/1ps

module fp_arith_bounce_detector
   import fp_bounce_pkg::*;
(
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [fp_bounce_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [fp_bounce_pkg::DATA_W-1:0]    pwdata,
   output logic      [fp_bounce_pkg::DATA_W-1:0]    prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   output logic                                     bounce,
   output logic                                     exception_pending_bit
);
   import fp_bounce_pkg::*;

   state_t s_r;
   state_t s_nxt;
   verdict_t verdict;

   function automatic exp_t widen(input logic [EXP_W-1:0] x);
      return exp_t'({3'h0, x});
   endfunction

   function automatic exp_t larger(input exp_t x, input exp_t y);
      return (x > y) ? x : y;
   endfunction

   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
      return addr == REG_CTRL || addr == REG_OPND_A || addr == REG_OPND_B
          || addr == REG_OPND_C || addr == REG_ISSUE || addr == REG_RESULT
          || addr == REG_EXC;
   endfunction

   function automatic operand_t take_opnd(input logic [DATA_W-1:0] d);
      operand_t o;
      o.sign = d[OPND_SIGN_BIT];
      o.exp  = d[OPND_EXP_LSB +: EXP_W];
      return o;
   endfunction

   function automatic logic [DATA_W-1:0] show_opnd(input operand_t o);
      logic [DATA_W-1:0] d;
      d = '0;
      d[OPND_SIGN_BIT]           = o.sign;
      d[OPND_EXP_LSB +: EXP_W]   = o.exp;
      return d;
   endfunction

   function automatic logic [DATA_W-1:0] reg_read(
      input logic [ADDR_W-1:0] addr,
      input state_t            s
   );
      logic [DATA_W-1:0] d;
      d = '0;
      unique case (addr)
         REG_CTRL: begin
            d[CTRL_FTZ_BIT]  = s.ctrl_ftz;
            d[CTRL_FAST_BIT] = s.ctrl_fast;
         end
         REG_OPND_A: d = show_opnd(s.a);
         REG_OPND_B: d = show_opnd(s.b);
         REG_OPND_C: d = show_opnd(s.c);
         REG_ISSUE: begin
            d[ISSUE_OP_LSB +: 5] = s.op;
            d[ISSUE_DP_BIT]      = s.dp;
         end
         REG_RESULT: begin
            d[RES_BOUNCE_BIT]           = s.res.bounce;
            d[RES_OVF_BIT]              = s.res.ovf;
            d[RES_UNF_BIT]              = s.res.unf;
            d[RES_LIKE_BIT]             = s.res.like;
            d[RES_DONE_BIT]             = s.done;
            d[RES_BUSY_BIT]             = s.run;
            d[RES_EXP_LSB +: EWRK_W]    = s.res.e;
         end
         REG_EXC: begin
            // Status overflow/underflow flags are not kept here at all:
            // support code sets them after confirming
            d[EXC_PEND_BIT] = s.exc_pend;
            d[EXC_OVF_BIT]  = s.exc_ovf;
            d[EXC_UNF_BIT]  = s.exc_unf;
         end
         default: d = '0;
      endcase
      return d;
   endfunction

   // Add-family verdict on an initial exponent
   function automatic verdict_t add_check(
      input exp_t e,
      input logic like,
      input logic dp,
      input logic uf_en
   );
      verdict_t v;
      v.e    = e;
      v.like = like;
      // Unlike-sign add shares the like-sign range
      v.ovf  = e >= (dp ? DP_OVF_THR : SP_OVF_THR);
      // Unlike-sign allows for cancellation over the whole mantissa
      if (like) begin
         v.unf = uf_en && e <= LSA_UNF_THR;
      end else begin
         v.unf = uf_en && e <= (dp ? DP_USA_UNF : SP_USA_UNF);
      end
      v.bounce = v.ovf || v.unf;
      return v;
   endfunction

   function automatic verdict_t evaluate(
      input fp_op_t   op,
      input logic     dp,
      input operand_t a,
      input operand_t b,
      input operand_t c,
      input logic     uf_en
   );
      verdict_t v;
      verdict_t va;
      exp_t     bias;
      exp_t     p;
      logic     b_sign;
      logic     p_sign;
      logic     c_sign;
      v      = '0;
      va     = '0;
      bias   = dp ? DP_BIAS : SP_BIAS;
      // Initial product exponent, still biased once
      p      = widen(a.exp) + widen(b.exp) - bias;
      // Compare-with-zero sees a positive zero second operand
      b_sign = (op == OP_CMPZ || op == OP_CMPEZ) ? 1'b0 : b.sign;
      p_sign = a.sign ^ b.sign ^ (op == OP_NMUL || op == OP_NMAC
                                  || op == OP_NMSC);
      c_sign = c.sign ^ (op == OP_MSC || op == OP_NMSC);
      unique case (op)
         OP_ADD: begin
            v = add_check(larger(widen(a.exp), widen(b.exp)),
                          a.sign == b.sign, dp, uf_en);
         end
         OP_SUB, OP_CMP, OP_CMPE: begin
            v = add_check(larger(widen(a.exp), widen(b.exp)),
                          a.sign != b.sign, dp, uf_en);
         end
         OP_CMPZ, OP_CMPEZ: begin
            v = add_check(widen(a.exp), a.sign != b_sign, dp, uf_en);
         end
         OP_MUL, OP_NMUL: begin
            v.e      = p;
            v.like   = 1'b0;
            v.ovf    = p >= (dp ? DP_OVF_THR : SP_OVF_THR);
            v.unf    = uf_en && p <= LSA_UNF_THR;
            v.bounce = v.ovf || v.unf;
         end
         OP_MAC, OP_MSC, OP_NMAC, OP_NMSC: begin
            // Product checked as a multiply, sum as an add
            va       = add_check(larger(p, widen(c.exp)),
                                 p_sign == c_sign, dp, uf_en);
            v.e      = va.e;
            v.like   = va.like;
            v.ovf    = va.ovf || p >= (dp ? DP_OVF_THR : SP_OVF_THR);
            v.unf    = va.unf || (uf_en && p <= LSA_UNF_THR);
            v.bounce = v.ovf || v.unf;
         end
         OP_DIV: begin
            v.e      = widen(a.exp) - widen(b.exp) + bias;
            v.like   = 1'b0;
            v.ovf    = v.e >= (dp ? DP_OVF_THR : SP_OVF_THR);
            v.unf    = uf_en && v.e <= DIV_UNF_THR;
            v.bounce = v.ovf || v.unf;
         end
         OP_CVT_DS: begin
            // Source is always double; result range is single
            v.e      = widen(a.exp);
            v.like   = 1'b0;
            v.ovf    = v.e >= CVT_OVF_THR;
            v.unf    = uf_en && v.e <= CVT_UNF_THR;
            v.bounce = v.ovf || v.unf;
         end
         OP_SQRT: v = '0;
         OP_CPY, OP_ABS, OP_NEG: v = '0;
         OP_CVT_SD: v = '0;
         default: v = '0;
      endcase
      return v;
   endfunction

   // Either flush mode lets hardware flush tiny results itself
   assign verdict = evaluate(s_r.op, s_r.dp, s_r.a, s_r.b, s_r.c,
                             !(s_r.ctrl_fast || s_r.ctrl_ftz));

   always_comb begin
      logic setup;
      logic wr;
      setup = psel && !penable;
      wr    = psel && penable && pwrite;
      s_nxt = s_r;
      if (setup && !pwrite) begin
         s_nxt.rdata = reg_read(paddr, s_r);
      end
      if (wr) begin
         unique case (paddr)
            REG_CTRL: begin
               s_nxt.ctrl_ftz  = pwdata[CTRL_FTZ_BIT];
               s_nxt.ctrl_fast = pwdata[CTRL_FAST_BIT];
            end
            REG_OPND_A: s_nxt.a = take_opnd(pwdata);
            REG_OPND_B: s_nxt.b = take_opnd(pwdata);
            REG_OPND_C: s_nxt.c = take_opnd(pwdata);
            REG_ISSUE: begin
               s_nxt.op   = fp_op_t'(pwdata[ISSUE_OP_LSB +: 5]);
               s_nxt.dp   = pwdata[ISSUE_DP_BIT];
               s_nxt.run  = 1'b1;
               s_nxt.done = 1'b0;
            end
            REG_EXC: begin
               // Write one to clear
               if (pwdata[EXC_PEND_BIT]) s_nxt.exc_pend = 1'b0;
               if (pwdata[EXC_OVF_BIT])  s_nxt.exc_ovf  = 1'b0;
               if (pwdata[EXC_UNF_BIT])  s_nxt.exc_unf  = 1'b0;
            end
            default: s_nxt.run = s_r.run;
         endcase
      end
      // One execute stage; the set below overrides a same-cycle clear
      if (s_r.run) begin
         s_nxt.run  = 1'b0;
         s_nxt.done = 1'b1;
         s_nxt.res  = verdict;
         if (verdict.bounce) begin
            s_nxt.exc_pend = 1'b1;
         end
         if (verdict.ovf) begin
            s_nxt.exc_ovf = 1'b1;
         end
         if (verdict.unf) begin
            s_nxt.exc_unf = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Zero-wait slave; read data was caught in the setup cycle
   assign pready                = 1'b1;
   assign pslverr               = psel && penable && !reg_hit(paddr);
   assign prdata                = s_r.rdata;
   assign bounce                = s_r.done && s_r.res.bounce;
   assign exception_pending_bit = s_r.exc_pend;

   // Helper terms for the checks below
   exp_t add_e;
   assign add_e = larger(widen(s_r.a.exp), widen(s_r.b.exp));

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sqrt_never_bounces: assert property (
      s_r.run && s_r.op == OP_SQRT |=> s_r.done && !s_r.res.bounce)
      else $error("square root bounced");

   a_move_never_bounces: assert property (
      s_r.run && (s_r.op inside {OP_CPY, OP_ABS, OP_NEG})
      |=> !s_r.res.bounce)
      else $error("copy, abs or negate bounced");

   a_widen_never_bounces: assert property (
      s_r.run && s_r.op == OP_CVT_SD |=> !s_r.res.bounce)
      else $error("single to double conversion bounced");

   a_add_dp_overflow: assert property (
      s_r.run && s_r.dp && s_r.op == OP_ADD
      |=> s_r.res.ovf == ($past(add_e) >= DP_OVF_THR))
      else $error("double add overflow verdict wrong");

   a_sub_sp_unlike_unf: assert property (
      s_r.run && !s_r.dp && s_r.op == OP_SUB && !s_r.ctrl_ftz
      && !s_r.ctrl_fast && s_r.a.sign == s_r.b.sign
      |=> s_r.res.unf == ($past(add_e) <= SP_USA_UNF) && !s_r.res.like)
      else $error("single subtract cancellation verdict wrong");

   a_mul_product_exp: assert property (
      s_r.run && (s_r.op inside {OP_MUL, OP_NMUL}) && s_r.dp
      |=> s_r.res.e == $past(widen(s_r.a.exp) + widen(s_r.b.exp)
                             - DP_BIAS))
      else $error("product exponent wrong");

   a_div_sp_unf: assert property (
      $past(s_r.run) && s_r.op == OP_DIV && !s_r.dp
      && !$past(s_r.ctrl_ftz) && !$past(s_r.ctrl_fast)
      |-> s_r.res.unf == (s_r.res.e <= DIV_UNF_THR))
      else $error("single divide underflow verdict wrong");

   a_cvt_ovf_edge: assert property (
      s_r.run && s_r.op == OP_CVT_DS
      |=> s_r.res.ovf == ($past(s_r.a.exp) >= EXP_W'(CVT_OVF_THR)))
      else $error("narrowing conversion overflow verdict wrong");

   a_pend_follows_bounce: assert property (
      s_r.run ##1 s_r.res.bounce |-> s_r.exc_pend ##1 s_r.exc_pend
      or (psel && penable && pwrite && paddr == REG_EXC))
      else $error("bounce did not raise pending bit");

   a_ovf_sets_bit: assert property (
      s_r.run && verdict.ovf |=> s_r.exc_ovf && s_r.exc_pend)
      else $error("overflow bounce did not set control bits");

   a_issue_latency: assert property (
      psel && penable && pwrite && paddr == REG_ISSUE
      |=> s_r.run && !s_r.done ##1 s_r.done && !s_r.run)
      else $error("verdict not ready two edges after issue");

   c_add_overflow:    cover property (s_r.run && s_r.op == OP_ADD
                                      ##1 s_r.res.ovf);
   c_mul_underflow:   cover property (s_r.run && s_r.op == OP_MUL
                                      ##1 s_r.res.unf);
   c_cvt_bounce:      cover property (s_r.run && s_r.op == OP_CVT_DS
                                      ##1 s_r.res.bounce);
   c_mac_normal:      cover property (s_r.run && s_r.op == OP_MAC
                                      ##1 !s_r.res.bounce);
   c_div_underflow:   cover property (s_r.run && s_r.op == OP_DIV
                                      ##1 s_r.res.unf);

   a_dp_like_unf: assert property (
      s_r.run && s_r.dp && s_r.op == OP_ADD && !s_r.ctrl_ftz
      && !s_r.ctrl_fast && s_r.a.sign == s_r.b.sign
      |=> s_r.res.unf == ($past(add_e) <= LSA_UNF_THR))
      else $error("double like-sign add underflow verdict wrong");

   a_cvt_unf_edge: assert property (
      s_r.run && s_r.op == OP_CVT_DS && !s_r.ctrl_ftz && !s_r.ctrl_fast
      |=> s_r.res.unf == ($past(s_r.a.exp) <= EXP_W'(CVT_UNF_THR)))
      else $error("narrowing conversion underflow verdict wrong");

   a_unf_sets_bit: assert property (
      s_r.run && verdict.unf |=> s_r.exc_unf && s_r.exc_pend)
      else $error("underflow bounce did not set control bits");

   // Checked on the raw exponent difference against the threshold less DP_BIAS
   a_div_dp_ovf: assert property (
      s_r.run && s_r.dp && s_r.op == OP_DIV
      |=> s_r.res.ovf == ($past(widen(s_r.a.exp) - widen(s_r.b.exp))
                          >= DP_OVF_THR - DP_BIAS))
      else $error("double divide overflow verdict wrong");

endmodule

// ===== verilog/fp_bounce_pkg.sv
// Constants, types and register map for the arithmetic bounce detector
package fp_bounce_pkg;

   // Exponent widths and the signed working width for initial exponents
   localparam int EXP_W  = 11;
   localparam int EWRK_W = 14;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   typedef logic signed [EWRK_W-1:0] exp_t;

   // Operation codes as written into the issue register
   typedef enum logic [4:0] {
      OP_ADD, OP_SUB, OP_CMP, OP_CMPE, OP_CMPZ, OP_CMPEZ,
      OP_MUL, OP_NMUL, OP_MAC, OP_MSC, OP_NMAC, OP_NMSC,
      OP_DIV, OP_SQRT, OP_CPY, OP_ABS, OP_NEG,
      OP_CVT_DS, OP_CVT_SD
   } fp_op_t;

   // Biased exponent values; SP figures are in 8-bit form
   localparam exp_t DP_BIAS       = 14'sh03FF;
   localparam exp_t SP_BIAS       = 14'sh007F;
   localparam exp_t DP_OVF_THR    = 14'sh07FD;
   localparam exp_t SP_OVF_THR    = 14'sh00FD;
   localparam exp_t DP_USA_UNF    = 14'sh003F;
   localparam exp_t SP_USA_UNF    = 14'sh001F;
   localparam exp_t LSA_UNF_THR   = 14'sh0000;
   localparam exp_t DIV_UNF_THR   = 14'sh0001;
   localparam exp_t CVT_OVF_THR   = 14'sh047D;
   localparam exp_t CVT_UNF_THR   = 14'sh0380;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_OPND_A = 8'h04;
   localparam logic [ADDR_W-1:0] REG_OPND_B = 8'h08;
   localparam logic [ADDR_W-1:0] REG_OPND_C = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_ISSUE  = 8'h10;
   localparam logic [ADDR_W-1:0] REG_RESULT = 8'h14;
   localparam logic [ADDR_W-1:0] REG_EXC    = 8'h18;

   // Field positions
   localparam int CTRL_FTZ_BIT   = 0;
   localparam int CTRL_FAST_BIT  = 1;
   localparam int OPND_EXP_LSB   = 0;
   localparam int OPND_SIGN_BIT  = 11;
   localparam int ISSUE_OP_LSB   = 0;
   localparam int ISSUE_DP_BIT   = 8;
   localparam int RES_BOUNCE_BIT = 0;
   localparam int RES_OVF_BIT    = 1;
   localparam int RES_UNF_BIT    = 2;
   localparam int RES_LIKE_BIT   = 3;
   localparam int RES_DONE_BIT   = 4;
   localparam int RES_BUSY_BIT   = 5;
   localparam int RES_EXP_LSB    = 16;
   localparam int EXC_OVF_BIT    = 2;
   localparam int EXC_UNF_BIT    = 3;
   localparam int EXC_PEND_BIT   = 31;

   typedef struct packed {
      logic             sign;
      logic [EXP_W-1:0] exp;
   } operand_t;

   typedef struct packed {
      logic bounce;
      logic ovf;
      logic unf;
      logic like;
      exp_t e;
   } verdict_t;

   typedef struct packed {
      logic              ctrl_ftz;
      logic              ctrl_fast;
      operand_t          a;
      operand_t          b;
      operand_t          c;
      fp_op_t            op;
      logic              dp;
      logic              run;
      logic              done;
      verdict_t          res;
      logic              exc_pend;
      logic              exc_ovf;
      logic              exc_unf;
      logic [DATA_W-1:0] rdata;
   } state_t;

endpackage
